// file: kick_master.sv
// microprocessor model that services the watchdog with kick falling edges
`timescale 1ns/1ps
`default_nettype none

module kick_master (
    // clock
    input  wire logic       sys_clk,
    // control from the bench
    input  wire logic       run,
    input  wire logic       hold_low,
    input  wire logic [7:0] period,
    // kick pin
    output var  logic       watchdog_kick
);
    logic [7:0] count_r = 8'h00;

    // two low cycles per period, so the pin filter sees each edge; driven high between pulses and while stopped, unless hold_low forces it low
    always @(posedge sys_clk) begin
        count_r <= (run && count_r < period - 8'h01) ? count_r + 8'h01 : 8'h00;
        watchdog_kick <= hold_low ? 1'b0 : !(run && count_r < 8'h02);
    end
endmodule : kick_master

`default_nettype wire

// file: supervisor_pkg.sv
// shared constants, types and the comparator glitch filter for the supply supervisor
`timescale 1ns/1ps
`default_nettype none

package supervisor_pkg;
    localparam int TW = 24;
    localparam int AW = 8;
    localparam int DW = 32;
    localparam int CLK_MHZ = 125;

    // register byte offsets
    localparam logic [AW-1:0] OFF_RST_ONE    = 8'h00;
    localparam logic [AW-1:0] OFF_RST_TWO    = 8'h04;
    localparam logic [AW-1:0] OFF_WD_TIME    = 8'h08;
    localparam logic [AW-1:0] OFF_GLITCH     = 8'h0c;
    localparam logic [AW-1:0] OFF_STATUS     = 8'h10;

    // status field positions
    localparam int ST_VALID_LO   = 0;
    localparam int ST_RESET_LO   = 2;
    localparam int ST_FAULT_N    = 4;
    localparam int ST_WD_RUN     = 5;
    localparam int ST_WD_STATE   = 6;
    localparam int ST_CONFIG     = 8;

    // timing figures as printed, and cycle counts derived from them
    localparam int RESET_MIN_NS   = 65000;
    localparam int WINDOW_MIN_NS  = 200000;
    localparam int RESET_MIN_CYC  = RESET_MIN_NS * CLK_MHZ / 1000;
    localparam int WINDOW_MIN_CYC = WINDOW_MIN_NS * CLK_MHZ / 1000;
    localparam logic [TW-1:0] GLITCH_DEFAULT = 24'h000010;

    // ratios between window figures, as shift amounts, and the fast kick limit
    localparam int LOWER_SHIFT   = 4;
    localparam int FAULT_SHIFT   = 3;
    localparam logic [1:0] FAST_KICK_LIMIT = 2'h2;

    localparam logic [TW-1:0] CNT_ONE  = 24'h000001;
    localparam logic [TW-1:0] CNT_ZERO = 24'h000000;
    localparam logic [DW-1:0] DATA_ZERO = 32'h00000000;

    typedef enum logic [1:0] {WD_OFF, WD_WINDOW, WD_FAULT} wd_state_t;
    typedef enum logic [1:0] {CFG_OPEN, CFG_HIGH, CFG_LOW} config_mode_t;

    typedef struct packed {
        logic          wr;
        logic          rd;
        logic [AW-1:0] addr;
        logic [DW-1:0] wdata;
    } reg_req_t;
endpackage : supervisor_pkg

module glitch_filter (
    // clock and reset
    input  wire logic                         sys_clk,
    input  wire logic                         reset,
    // level in and filtered level out
    input  wire logic                         level_in,
    input  wire logic [supervisor_pkg::TW-1:0] limit,
    output logic                              level_out
);
    logic [supervisor_pkg::TW-1:0] cnt_r;
    logic                          level_r;
    wire  differs = level_in != level_r;
    wire  held    = (cnt_r + supervisor_pkg::CNT_ONE) >= limit;

    // state moves only after the new value held for the full limit
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            cnt_r   <= supervisor_pkg::CNT_ZERO;
            level_r <= 1'b0;
        end else if (!differs) begin
            cnt_r   <= supervisor_pkg::CNT_ZERO;
        end else if (held) begin
            cnt_r   <= supervisor_pkg::CNT_ZERO;
            level_r <= level_in;
        end else begin
            cnt_r   <= cnt_r + supervisor_pkg::CNT_ONE;
        end
    end

    assign level_out = level_r;

    filter_hold_a: assert property (@(posedge sys_clk) disable iff (reset)
        $changed(level_r) |-> ($past(cnt_r) + supervisor_pkg::CNT_ONE) >= $past(limit)
            && $past(level_in) == level_r)
        else $error("filtered level changed before the hold time");
endmodule : glitch_filter

`default_nettype wire

// file: supply_reset_window_watchdog.sv
// two-channel supply reset supervisor with window watchdog
// Contract
// - reset held low while output invalid
// - valid starts timer, release after timeout
// - invalid during timing clears the timer
// - monitor changes only after glitch-filter hold
// - only kick falling edges count as service
// - over two kicks in fast period faults
// - no kick within slow period faults
// - slow period is sixteen fast periods
// - fault low for eighth of upper bound
// - kicks ignored while fault timer runs
// - idle kick gives repeating fault pulse train
// - reset going low releases fault output
// - watchdog enabled when enable pin low
// - config high: sequenced, independent timers, both gate
// - config low: sequenced, shared timer, both release
// - config open: simultaneous, channel one gates watchdog
// - default reset timeout about 65 us
// - reset timeout scales linearly with setting
// - lower bound is upper bound over sixteen
// - default window upper bound about 200 us
//
// Added by the designer: the register addresses and strobed register access.
`timescale 1ns/1ps
`default_nettype none

module supply_reset_window_watchdog #(
    parameter logic [supervisor_pkg::TW-1:0] RESET_DEFAULT_CYC =
        supervisor_pkg::TW'(supervisor_pkg::RESET_MIN_CYC),
    parameter logic [supervisor_pkg::TW-1:0] WINDOW_DEFAULT_CYC =
        supervisor_pkg::TW'(supervisor_pkg::WINDOW_MIN_CYC)
) (
    // clock and reset
    input  wire logic                          sys_clk,
    input  wire logic                          reset,
    // register port
    input  wire supervisor_pkg::reg_req_t      reg_req,
    output logic [supervisor_pkg::DW-1:0]      reg_rdata,
    // comparator results, high when output above threshold
    input  wire logic [1:0]                    output_sense_valid,
    // configuration pin, decoded as high, low or open
    input  wire logic                          config_is_high,
    input  wire logic                          config_is_low,
    // watchdog pins
    input  wire logic                          watchdog_kick,
    input  wire logic                          watchdog_enable_n,
    // outputs
    output logic                               channel_two_start,
    output logic                               channel_one_reset_n,
    output logic                               channel_two_reset_n,
    output logic                               watchdog_fault_n
);
    localparam int NSYNC = 6;
    localparam int TW    = supervisor_pkg::TW;

    // pin synchronisers: three flops, change taken when second and third agree
    wire  [NSYNC-1:0] pin_raw = {config_is_low, config_is_high, watchdog_enable_n,
                                 watchdog_kick, output_sense_valid};
    localparam logic [NSYNC-1:0] PIN_RESET = 6'h04;
    logic [NSYNC-1:0] sync1_r;
    logic [NSYNC-1:0] sync2_r;
    logic [NSYNC-1:0] sync3_r;
    logic [NSYNC-1:0] stable_r;
    // channel two start only trusts the config decode once the synchroniser has filled after reset
    localparam int SETTLE = 4;
    logic [SETTLE-1:0] settle_r;
    wire              pins_settled = settle_r[SETTLE-1];

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            sync1_r  <= PIN_RESET;
            sync2_r  <= PIN_RESET;
            sync3_r  <= PIN_RESET;
            stable_r <= PIN_RESET;
            settle_r <= '0;
        end else begin
            sync1_r  <= pin_raw;
            sync2_r  <= sync1_r;
            sync3_r  <= sync2_r;
            stable_r <= (sync2_r & sync3_r) | (stable_r & (sync2_r | sync3_r));
            settle_r <= {settle_r[SETTLE-2:0], 1'b1};
        end
    end

    wire [1:0] sense_s   = stable_r[1:0];
    wire       kick_s    = stable_r[2];
    wire       wd_dis_s  = stable_r[3];
    wire       cfg_hi_s  = stable_r[4];
    wire       cfg_lo_s  = stable_r[5];

    supervisor_pkg::config_mode_t cfg_mode;
    assign cfg_mode = cfg_hi_s ? supervisor_pkg::CFG_HIGH :
                      cfg_lo_s ? supervisor_pkg::CFG_LOW : supervisor_pkg::CFG_OPEN;

    // timing registers, zero means left at default
    logic [TW-1:0] rst_one_time_r;
    logic [TW-1:0] rst_two_time_r;
    logic [TW-1:0] wd_time_r;
    logic [TW-1:0] glitch_time_r;
    logic [supervisor_pkg::DW-1:0] rdata_r;

    wire hit_rst_one = reg_req.addr == supervisor_pkg::OFF_RST_ONE;
    wire hit_rst_two = reg_req.addr == supervisor_pkg::OFF_RST_TWO;
    wire hit_wd      = reg_req.addr == supervisor_pkg::OFF_WD_TIME;
    wire hit_glitch  = reg_req.addr == supervisor_pkg::OFF_GLITCH;
    wire hit_status  = reg_req.addr == supervisor_pkg::OFF_STATUS;
    wire [TW-1:0] wfield = reg_req.wdata[TW-1:0];

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            rst_one_time_r <= supervisor_pkg::CNT_ZERO;
            rst_two_time_r <= supervisor_pkg::CNT_ZERO;
            wd_time_r      <= supervisor_pkg::CNT_ZERO;
            glitch_time_r  <= supervisor_pkg::CNT_ZERO;
        end else if (reg_req.wr) begin
            if (hit_rst_one) rst_one_time_r <= wfield;
            if (hit_rst_two) rst_two_time_r <= wfield;
            if (hit_wd)      wd_time_r      <= wfield;
            if (hit_glitch)  glitch_time_r  <= wfield;
        end
    end

    // effective counts
    wire [TW-1:0] rst_time_one = (rst_one_time_r == supervisor_pkg::CNT_ZERO) ?
                                 RESET_DEFAULT_CYC : rst_one_time_r;
    wire [TW-1:0] rst_time_two = (rst_two_time_r == supervisor_pkg::CNT_ZERO) ?
                                 RESET_DEFAULT_CYC : rst_two_time_r;
    wire [TW-1:0] upper_cyc    = (wd_time_r == supervisor_pkg::CNT_ZERO) ?
                                 WINDOW_DEFAULT_CYC : wd_time_r;
    wire [TW-1:0] lower_cyc    = upper_cyc >> supervisor_pkg::LOWER_SHIFT;
    wire [TW-1:0] fault_cyc    = upper_cyc >> supervisor_pkg::FAULT_SHIFT;
    wire [TW-1:0] glitch_cyc   = (glitch_time_r == supervisor_pkg::CNT_ZERO) ?
                                 supervisor_pkg::GLITCH_DEFAULT : glitch_time_r;

    // glitch-filtered monitor state per channel
    logic [1:0] ch_valid;
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_filter
            glitch_filter u_filter (
                .sys_clk   (sys_clk),
                .reset     (reset),
                .level_in  (sense_s[gi]),
                .limit     (glitch_cyc),
                .level_out (ch_valid[gi])
            );
        end
    endgenerate

    // channel two regulator start: sequenced unless open
    // the reset value of the config flops reads as open, so hold off until settled
    wire ch_two_start_nxt = pins_settled &
                            ((cfg_mode == supervisor_pkg::CFG_OPEN) | ch_valid[0]);

    // reset timers; low config shares timer one over both channels
    wire shared_mode = cfg_mode == supervisor_pkg::CFG_LOW;
    wire [1:0] tmr_run;
    assign tmr_run[0] = shared_mode ? (ch_valid[0] & ch_valid[1]) : ch_valid[0];
    assign tmr_run[1] = ch_valid[1] & ~shared_mode;
    wire [TW-1:0] tmr_limit [2];
    assign tmr_limit[0] = rst_time_one;
    assign tmr_limit[1] = rst_time_two;

    logic [TW-1:0] rst_cnt_r [2];
    logic [1:0]    tmr_done;
    logic [1:0]    reset_n_r;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_timer
            assign tmr_done[gi] = tmr_run[gi] && (rst_cnt_r[gi] >= tmr_limit[gi]);
            always_ff @(posedge sys_clk or posedge reset) begin
                if (reset) begin
                    rst_cnt_r[gi] <= supervisor_pkg::CNT_ZERO;
                end else if (!tmr_run[gi]) begin
                    rst_cnt_r[gi] <= supervisor_pkg::CNT_ZERO;
                end else if (!tmr_done[gi]) begin
                    rst_cnt_r[gi] <= rst_cnt_r[gi] + supervisor_pkg::CNT_ONE;
                end
            end
        end
    endgenerate

    wire [1:0] reset_n_nxt;
    assign reset_n_nxt[0] = ch_valid[0] & tmr_done[0];
    assign reset_n_nxt[1] = ch_valid[1] & (shared_mode ? tmr_done[0] : tmr_done[1]);

    // watchdog gate per configuration
    wire wd_gate = (cfg_mode == supervisor_pkg::CFG_OPEN) ? reset_n_r[0] :
                   (reset_n_r[0] & reset_n_r[1]);
    wire wd_run  = wd_gate & ~wd_dis_s;
    wire any_reset_low = ~(reset_n_r[0] & reset_n_r[1]);

    // kick edge detection on the stable level
    logic kick_prev_r;
    wire  kick_fall = kick_prev_r & ~kick_s;

    supervisor_pkg::wd_state_t wd_state_r;
    supervisor_pkg::wd_state_t wd_state_nxt;
    logic [TW-1:0] win_cnt_r;
    logic [TW-1:0] win_cnt_nxt;
    logic [1:0]    kick_cnt_r;
    logic [1:0]    kick_cnt_nxt;
    logic          fault_n_r;

    wire in_fast    = win_cnt_r < lower_cyc;
    wire win_expire = (win_cnt_r + supervisor_pkg::CNT_ONE) >= upper_cyc;
    wire flt_expire = (win_cnt_r + supervisor_pkg::CNT_ONE) >= fault_cyc;

    always_comb begin
        wd_state_nxt = wd_state_r;
        win_cnt_nxt  = win_cnt_r + supervisor_pkg::CNT_ONE;
        kick_cnt_nxt = kick_cnt_r;
        if (!wd_run) begin
            wd_state_nxt = supervisor_pkg::WD_OFF;
            win_cnt_nxt  = supervisor_pkg::CNT_ZERO;
            kick_cnt_nxt = 2'h0;
        end else begin
            unique case (wd_state_r)
                supervisor_pkg::WD_OFF: begin
                    wd_state_nxt = supervisor_pkg::WD_WINDOW;
                    win_cnt_nxt  = supervisor_pkg::CNT_ZERO;
                    kick_cnt_nxt = 2'h0;
                end
                supervisor_pkg::WD_WINDOW: begin
                    if (kick_fall && in_fast) begin
                        if (kick_cnt_r == supervisor_pkg::FAST_KICK_LIMIT) begin
                            wd_state_nxt = supervisor_pkg::WD_FAULT;
                            win_cnt_nxt  = supervisor_pkg::CNT_ZERO;
                            kick_cnt_nxt = 2'h0;
                        end else begin
                            kick_cnt_nxt = kick_cnt_r + 2'h1;
                        end
                    end else if (kick_fall) begin
                        win_cnt_nxt  = supervisor_pkg::CNT_ZERO;
                        kick_cnt_nxt = 2'h0;
                    end else if (win_expire) begin
                        wd_state_nxt = supervisor_pkg::WD_FAULT;
                        win_cnt_nxt  = supervisor_pkg::CNT_ZERO;
                        kick_cnt_nxt = 2'h0;
                    end
                end
                supervisor_pkg::WD_FAULT: begin
                    // kicks are not looked at here
                    if (any_reset_low || flt_expire) begin
                        wd_state_nxt = supervisor_pkg::WD_WINDOW;
                        win_cnt_nxt  = supervisor_pkg::CNT_ZERO;
                    end
                end
                default: begin
                    wd_state_nxt = supervisor_pkg::WD_OFF;
                    win_cnt_nxt  = supervisor_pkg::CNT_ZERO;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            wd_state_r  <= supervisor_pkg::WD_OFF;
            win_cnt_r   <= supervisor_pkg::CNT_ZERO;
            kick_cnt_r  <= 2'h0;
            kick_prev_r <= 1'b1;
            fault_n_r   <= 1'b1;
            reset_n_r   <= 2'h0;
            channel_two_start <= 1'b0;
        end else begin
            wd_state_r  <= wd_state_nxt;
            win_cnt_r   <= win_cnt_nxt;
            kick_cnt_r  <= kick_cnt_nxt;
            kick_prev_r <= kick_s;
            fault_n_r   <= wd_state_nxt != supervisor_pkg::WD_FAULT;
            reset_n_r   <= reset_n_nxt;
            channel_two_start <= ch_two_start_nxt;
        end
    end

    assign channel_one_reset_n = reset_n_r[0];
    assign channel_two_reset_n = reset_n_r[1];
    assign watchdog_fault_n    = fault_n_r;

    // register read, data one cycle after the strobe, zero elsewhere
    logic [supervisor_pkg::DW-1:0] status_word;
    always_comb begin
        status_word = supervisor_pkg::DATA_ZERO;
        status_word[supervisor_pkg::ST_VALID_LO +: 2] = ch_valid;
        status_word[supervisor_pkg::ST_RESET_LO +: 2] = reset_n_r;
        status_word[supervisor_pkg::ST_FAULT_N]       = fault_n_r;
        status_word[supervisor_pkg::ST_WD_RUN]        = wd_run;
        status_word[supervisor_pkg::ST_WD_STATE +: 2] = wd_state_r;
        status_word[supervisor_pkg::ST_CONFIG +: 2]   = cfg_mode;
    end

    wire [supervisor_pkg::DW-1:0] rd_mux =
        hit_rst_one ? {8'h00, rst_one_time_r} :
        hit_rst_two ? {8'h00, rst_two_time_r} :
        hit_wd      ? {8'h00, wd_time_r} :
        hit_glitch  ? {8'h00, glitch_time_r} :
        hit_status  ? status_word : supervisor_pkg::DATA_ZERO;

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) rdata_r <= supervisor_pkg::DATA_ZERO;
        else if (reg_req.rd) rdata_r <= rd_mux;
        else rdata_r <= supervisor_pkg::DATA_ZERO;
    end
    assign reg_rdata = rdata_r;

    // checks
    invalid_holds_reset_a: assert property (@(posedge sys_clk) disable iff (reset)
        !ch_valid[0] |=> !channel_one_reset_n)
        else $error("channel one reset released while output invalid");

    release_after_timeout_a: assert property (@(posedge sys_clk) disable iff (reset)
        $rose(channel_one_reset_n) |-> $past(rst_cnt_r[0]) >= $past(rst_time_one))
        else $error("channel one reset released before timeout");

    invalid_clears_timer_a: assert property (@(posedge sys_clk) disable iff (reset)
        !tmr_run[0] |=> rst_cnt_r[0] == supervisor_pkg::CNT_ZERO)
        else $error("reset timer not cleared when supply invalid");

    rising_kick_ignored_a: assert property (@(posedge sys_clk) disable iff (reset)
        wd_run && wd_state_r == supervisor_pkg::WD_WINDOW && !kick_fall && !win_expire
        |=> wd_state_r == supervisor_pkg::WD_WINDOW && win_cnt_r == $past(win_cnt_r) + 1)
        else $error("window restarted without a falling kick");

    fast_kicks_fault_a: assert property (@(posedge sys_clk) disable iff (reset)
        wd_run && wd_state_r == supervisor_pkg::WD_WINDOW && kick_fall && in_fast
        && kick_cnt_r == 2'h2 |=> !watchdog_fault_n)
        else $error("third fast kick did not fault");

    slow_window_fault_a: assert property (@(posedge sys_clk) disable iff (reset)
        wd_run && wd_state_r == supervisor_pkg::WD_WINDOW && !kick_fall && win_expire
        |=> !watchdog_fault_n)
        else $error("window expiry did not fault");

    fault_low_time_a: assert property (@(posedge sys_clk) disable iff (reset)
        wd_run && wd_state_r == supervisor_pkg::WD_FAULT && !any_reset_low
        && win_cnt_r + 1 < fault_cyc |=> !watchdog_fault_n)
        else $error("fault output released early");

    fault_kick_ignored_a: assert property (@(posedge sys_clk) disable iff (reset)
        wd_state_r == supervisor_pkg::WD_FAULT && kick_fall && wd_run
        |=> kick_cnt_r == 2'h0)
        else $error("kick counted during fault time");

    reset_releases_fault_a: assert property (@(posedge sys_clk) disable iff (reset)
        !watchdog_fault_n && any_reset_low |=> watchdog_fault_n)
        else $error("fault output held while a reset is low");

    disable_pin_a: assert property (@(posedge sys_clk) disable iff (reset)
        wd_dis_s |=> watchdog_fault_n && wd_state_r == supervisor_pkg::WD_OFF)
        else $error("watchdog active while disabled");

    cover_slow_fault_c: cover property (@(posedge sys_clk) disable iff (reset)
        wd_state_r == supervisor_pkg::WD_WINDOW && win_expire && !kick_fall);
    cover_fast_fault_c: cover property (@(posedge sys_clk) disable iff (reset)
        kick_fall && in_fast && kick_cnt_r == 2'h2);
    cover_shared_release_c: cover property (@(posedge sys_clk) disable iff (reset)
        shared_mode && $rose(channel_two_reset_n));
    cover_pulse_train_c: cover property (@(posedge sys_clk) disable iff (reset)
        $rose(watchdog_fault_n) && wd_run);
endmodule : supply_reset_window_watchdog

`default_nettype wire

// file: supply_reset_window_watchdog_tb.sv
// self-checking bench for the supply supervisor and window watchdog
`timescale 1ns/1ps
`default_nettype none

module supply_reset_window_watchdog_tb;
    logic                     sys_clk;
    logic                     reset;
    supervisor_pkg::reg_req_t req;
    logic [31:0]              rdata;
    logic [31:0]              rd;
    logic [1:0]               sense;
    logic                     cfg_hi;
    logic                     cfg_lo;
    logic                     kick;
    logic                     enable_n;
    logic                     ch2_start;
    logic                     channel_one_reset_n_n;
    logic                     channel_two_reset_n_n;
    logic                     fault_n;
    logic                     run;
    logic                     hold_low;
    logic [7:0]               period;
    int                       fail_count;
    int                       checks;
    int                       n;
    int                       lows;

    supply_reset_window_watchdog #(.RESET_DEFAULT_CYC(24'h000028),
        .WINDOW_DEFAULT_CYC(24'h000040)) u_dut (
        .sys_clk(sys_clk), .reset(reset), .reg_req(req), .reg_rdata(rdata),
        .output_sense_valid(sense), .config_is_high(cfg_hi), .config_is_low(cfg_lo),
        .watchdog_kick(kick), .watchdog_enable_n(enable_n), .channel_two_start(ch2_start),
        .channel_one_reset_n(channel_one_reset_n_n), .channel_two_reset_n(channel_two_reset_n_n),
        .watchdog_fault_n(fault_n));
    kick_master u_kick (.sys_clk(sys_clk), .run(run), .hold_low(hold_low),
        .period(period), .watchdog_kick(kick));

    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    task automatic close_out();
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : close_out

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic in_range(input string what, input int lo, input int hi, input int got);
        checks++;
        if (got < lo || got > hi) begin
            fail_count++;
            $display("MISMATCH %s expected %0d..%0d seen %0d", what, lo, hi, got);
        end
    endtask : in_range

    function automatic logic pick(input int w);
        return (w == 0) ? channel_one_reset_n_n : (w == 1) ? channel_two_reset_n_n : fault_n;
    endfunction : pick

    // cycles until output w shows v; a required level that never comes ends the run
    task automatic wait_for(input int w, input logic v, input int lim, input bit must,
                            output int cnt);
        cnt = 0;
        while (pick(w) !== v && cnt < lim) begin
            @(posedge sys_clk);
            #1;
            cnt++;
        end
        if (must && pick(w) !== v) begin
            fail_count++;
            $display("MISMATCH output %0d expected %b seen timeout", w, v);
            close_out();
        end
    endtask : wait_for

    task automatic watch(input int cyc, output int low_cnt);
        low_cnt = 0;
        repeat (cyc) begin
            @(posedge sys_clk);
            #1;
            if (fault_n !== 1'b1) low_cnt++;
        end
    endtask : watch

    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        req.wr <= 1'b1;
        req.addr <= a;
        req.wdata <= d;
        @(posedge sys_clk);
        req.wr <= 1'b0;
    endtask : reg_wr

    task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge sys_clk);
        req.rd <= 1'b1;
        req.addr <= a;
        @(posedge sys_clk);
        req.rd <= 1'b0;
        #1;
        d = rdata;
    endtask : reg_rd

    initial begin
        reset = 1'b1;
        req = '0;
        sense = 2'b00;
        cfg_hi = 1'b0;
        cfg_lo = 1'b0;
        enable_n = 1'b0;
        run = 1'b0;
        hold_low = 1'b0;
        period = 8'h14;
        fail_count = 0;
        checks = 0;
        // startup in low, high and open configuration, each from power-up
        for (int m = 2; m >= 0; m--) begin
            cfg_hi <= (m == 1);
            cfg_lo <= (m == 2);
            sense <= 2'b00;
            reset <= 1'b1;
            repeat (20) @(posedge sys_clk);
            reset <= 1'b0;
            #1;
            check("reset one", 32'h0, 32'(channel_one_reset_n_n));
            check("fault idle", 32'h1, 32'(fault_n));
            check("start at reset", 32'h0, 32'(ch2_start));
            repeat (10) @(posedge sys_clk);
            #1;
            check("second start", 32'(m == 0), 32'(ch2_start));
            sense <= 2'b01;
            repeat (150) @(posedge sys_clk);
            check("second start", 32'h1, 32'(ch2_start));
            check("reset one alone", 32'(m != 2), 32'(channel_one_reset_n_n));
            reg_rd(supervisor_pkg::OFF_STATUS, rd);
            check("watchdog gate", 32'(m == 0), 32'(rd[5]));
            sense <= 2'b11;
            repeat (100) @(posedge sys_clk);
            #1;
            check("both resets", 32'h3, {30'h0, channel_one_reset_n_n, channel_two_reset_n_n});
            $display("test config %0d done", m);
        end
        for (int a = 0; a < 24; a += 4) begin
            if (a != 16) begin
                reg_rd(8'(a), rd);
                check("register idle", 32'h0, rd);
            end
        end
        sense <= 2'b10;
        wait_for(0, 1'b0, 40, 1'b1, n);
        sense <= 2'b11;
        wait_for(0, 1'b1, 100, 1'b1, n);
        in_range("release delay", 56, 68, n);
        sense <= 2'b10;
        repeat (8) @(posedge sys_clk);
        sense <= 2'b11;
        wait_for(0, 1'b0, 40, 1'b0, n);
        check("short glitch", 32'h1, 32'(channel_one_reset_n_n));
        sense <= 2'b10;
        repeat (40) @(posedge sys_clk);
        sense <= 2'b11;
        repeat (30) @(posedge sys_clk);
        sense <= 2'b10;
        repeat (40) @(posedge sys_clk);
        #1;
        check("timer cleared", 32'h0, 32'(channel_one_reset_n_n));
        sense <= 2'b11;
        wait_for(0, 1'b1, 100, 1'b1, n);
        in_range("restart delay", 56, 68, n);
        $display("test supervisor done");
        reg_wr(supervisor_pkg::OFF_WD_TIME, 32'h00000100);
        reg_rd(supervisor_pkg::OFF_WD_TIME, rd);
        check("window bound", 32'h00000100, rd);
        wait_for(2, 1'b0, 400, 1'b1, n);
        wait_for(2, 1'b1, 40, 1'b1, n);
        wait_for(2, 1'b0, 300, 1'b1, n);
        in_range("fault high", 255, 257, n);
        wait_for(2, 1'b1, 40, 1'b1, n);
        in_range("fault low", 31, 33, n);
        run <= 1'b1;
        watch(600, lows);
        check("steady kicks", 32'h0, 32'(lows));
        reg_wr(supervisor_pkg::OFF_STATUS, 32'h0);
        reg_wr(8'h14, 32'h000000ff);
        reg_rd(supervisor_pkg::OFF_STATUS, rd);
        check("status", 32'h0000007f, rd);
        reg_rd(8'h14, rd);
        check("unmapped", 32'h0, rd);
        hold_low <= 1'b1;
        wait_for(2, 1'b0, 300, 1'b1, n);
        in_range("held kick", 230, 264, n);
        hold_low <= 1'b0;
        period <= 8'h04;
        wait_for(2, 1'b1, 40, 1'b1, n);
        wait_for(2, 1'b0, 40, 1'b1, n);
        wait_for(2, 1'b1, 40, 1'b1, n);
        in_range("fault low kicked", 31, 33, n);
        wait_for(2, 1'b0, 40, 1'b1, n);
        sense <= 2'b10;
        wait_for(0, 1'b0, 40, 1'b1, n);
        wait_for(2, 1'b1, 2, 1'b1, n);
        run <= 1'b0;
        sense <= 2'b11;
        enable_n <= 1'b1;
        wait_for(0, 1'b1, 100, 1'b1, n);
        watch(600, lows);
        check("watchdog off", 32'h0, 32'(lows));
        $display("test watchdog done");
        close_out();
    end
endmodule : supply_reset_window_watchdog_tb

`default_nettype wire
